// ---- hw/rstc_ctrl.sv ----
/*
 reset controller: gathers reset requests, sequences fuse reload, start-up
 delay and boot scan, records the cause, offers a protected software reset.
 assumes a classic wishbone master on clk_i, detector and pin levels
 asynchronous to clk_i, and unlock/instruction pulses on clk_i.
*/
// Register access over Wishbone was chosen for this implementation.
// Contract
// [RL1] controller always active; sources request only when enabled; the code gates only the pin, brown-out requests whatever fuse_bod_en_i says
// [RL2] fuse-loaded values reloaded after every reset
// [RL3] cause of last reset readable in the flag register
// [RL4] flags: 5 debugger, 4 soft, 3 watchdog, 2 pin, 1 brown-out, 0 power-on
// [RL5] power-on always enabled, holds reset until initialisation ends
// [RL6] power-on drop re-enters reset with no added delay
// [RL7] brown-out resets; unused detection forces minimum trigger level
// [RL8] enabled pin reset holds reset while pin low
// [RL9] watchdog time-out issues a system reset
// [RL10] writing one to soft trigger starts reset at once
// [RL11] only the external debugger drives the debug reset request
// [RL12] all resets reload fuses; only supply resets reset debug logic
// [RL13] initialisation after release; supply resets add start-up delay
// [RL14] initialisation lengthened when boot memory scan is selected
// [RL15] controller works in active and every sleep mode
// [RL16] soft reset write accepted only within four instructions of key
// [RL17] unlocked-less writes to soft reset register are ignored
// [RL18] flags clear on write one; power-on clears all but power-on
// [RL19] after power-on only power-on flag set until boot completes
// [RL20] soft trigger always reads zero
// [RL21] requests ored into one reset, released after initialisation
// [RL22] every source requesting before boot completes gets its flag; a boot with power-on seen keeps only the power-on flag
`timescale 1ns/1ns
`include "rstc_defines.svh"
module rstc_ctrl
   import rstc_pkg::*;
#(
   parameter int TW              = 20,
   parameter int LOAD_CYCLES     = 8,
   parameter int SUT_STEP_CYCLES = 20000,
   parameter int SCAN_CYCLES     = 4096
)
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output      logic [31:0] wb_dat_o,
   output      logic        wb_ack_o,
   // reset sources, asynchronous
   input  wire logic        por_det_i,
   input  wire logic        bod_det_i,
   input  wire logic        reset_pin_n_i,
   input  wire logic        wdt_timeout_i,
   input  wire logic        dbg_reset_req_i,
   // fuses, asynchronous levels
   input  wire logic        fuse_pin_reset_en_i,
   input  wire logic        fuse_bod_en_i,
   input  wire logic [2:0]  fuse_bod_level_i,
   input  wire logic [2:0]  fuse_startup_sel_i,
   input  wire logic        fuse_boot_scan_i,
   // cpu protection, same clock
   input  wire logic        unlock_key_i,
   input  wire logic        insn_done_i,
   // reset outputs
   output      logic        sys_reset_o,
   output      logic        dbg_reset_o,
   output      logic        fuse_reload_o,
   output      logic        scan_run_o,
   output      logic [2:0]  bod_level_o
);

   localparam int A_SW_MAX = 3;

   logic [13:0]          sync_s;
   logic                 por_s;
   logic                 bod_s;
   logic                 pin_n_s;
   logic                 wdt_s;
   logic                 dbg_s;
   logic                 f_pin_s;
   logic                 f_bod_s;
   logic [2:0]           f_lvl_s;
   logic [2:0]           f_sut_s;
   logic                 f_scan_s;
   rstc_state_type       state_reg;
   rstc_state_type       state_next;
   logic [5:0]           req_vec;
   logic                 any_req;
   logic [5:0]           seen_reg;
   logic [5:0]           seen_next;
   logic [5:0]           flags_reg;
   logic [5:0]           flags_next;
   logic                 commit;
   logic                 pin_en_reg;
   logic                 sw_req_reg;
   logic [2:0]           unlock_reg;
   logic                 unlocked;
   logic                 wr_fire;
   logic                 sw_accept;
   logic                 tmr_start;
   logic [TW-1:0]        tmr_load;
   logic                 tmr_done;

   // sampled address decode, index times four
   function automatic logic reg_hit(input logic [7:0] adr,
                                    input logic [5:0] idx);
      reg_hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
   endfunction

   function automatic logic [TW-1:0] cycles(input logic [2:0] mul,
                                            input int         step);
      cycles = TW'(mul) * TW'(step);
   endfunction

   // pin bit idles high, every other level idles low
   rstc_sync2 #(.WIDTH(14)) u_sync
   (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .async_i   ({por_det_i, bod_det_i, reset_pin_n_i, wdt_timeout_i,
                   dbg_reset_req_i, fuse_pin_reset_en_i, fuse_bod_en_i,
                   fuse_bod_level_i, fuse_startup_sel_i, fuse_boot_scan_i}),
      .rst_val_i (14'h0800),
      .sync_o    (sync_s)
   );

   assign {por_s, bod_s, pin_n_s, wdt_s, dbg_s, f_pin_s, f_bod_s,
           f_lvl_s, f_sut_s, f_scan_s} = sync_s;

   rstc_timer #(.TW(TW)) u_timer
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (tmr_start),
      .load_i  (tmr_load),
      .done_o  (tmr_done)
   );

   // [RL1] request sources, only the pin gated by its enable
   // [RL11] debugger request taken as given
   always_comb
   begin
      req_vec                = '0;
      req_vec[`RSTC_F_POR]   = por_s;
      req_vec[`RSTC_F_BOD]   = bod_s;
      // [RL8] pin low requests only when enabled
      req_vec[`RSTC_F_PIN]   = pin_en_reg & ~pin_n_s;
      // [RL9] watchdog time-out request
      req_vec[`RSTC_F_WDT]   = wdt_s;
      req_vec[`RSTC_F_SOFT]  = sw_req_reg;
      req_vec[`RSTC_F_DBG]   = dbg_s;
   end

   // [RL21] one combined reset request
   assign any_req = |req_vec;

   // [RL13] sequencer with start-up delay for supply resets
   always_comb
   begin
      state_next = state_reg;
      tmr_start  = 1'b0;
      tmr_load   = '0;
      unique case (state_reg)
         RSTC_HOLD:
         begin
            if (!any_req)
            begin
               state_next = RSTC_LOAD;
               tmr_start  = 1'b1;
               tmr_load   = TW'(LOAD_CYCLES);
            end
         end
         RSTC_LOAD:
         begin
            if (tmr_done && (seen_reg[`RSTC_F_POR] ||
                             seen_reg[`RSTC_F_BOD]) && (f_sut_s != 3'h0))
            begin
               state_next = RSTC_START;
               tmr_start  = 1'b1;
               tmr_load   = cycles(f_sut_s, SUT_STEP_CYCLES);
            end
            // [RL14] optional boot memory scan
            else if (tmr_done && f_scan_s)
            begin
               state_next = RSTC_SCAN;
               tmr_start  = 1'b1;
               tmr_load   = TW'(SCAN_CYCLES);
            end
            else if (tmr_done)
            begin
               state_next = RSTC_RUN;
            end
         end
         RSTC_START:
         begin
            if (tmr_done && f_scan_s)
            begin
               state_next = RSTC_SCAN;
               tmr_start  = 1'b1;
               tmr_load   = TW'(SCAN_CYCLES);
            end
            else if (tmr_done)
            begin
               state_next = RSTC_RUN;
            end
         end
         RSTC_SCAN:
         begin
            if (tmr_done)
            begin
               state_next = RSTC_RUN;
            end
         end
         RSTC_RUN:
         begin
         end
         default:
         begin
            state_next = RSTC_HOLD;
         end
      endcase
      // [RL6] any request, power drop included, preempts the sequence
      if (any_req)
      begin
         state_next = RSTC_HOLD;
         tmr_start  = 1'b0;
      end
   end

   assign commit = (state_reg != RSTC_RUN) && (state_next == RSTC_RUN);

   // [RL22] remember every source seen during this reset
   assign seen_next = commit ? 6'h00 : (seen_reg | req_vec);

   // [RL15] no sleep gating anywhere in the controller
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= RSTC_HOLD;
         seen_reg  <= 6'h00;
      end
      else
      begin
         state_reg <= state_next;
         seen_reg  <= seen_next;
      end
   end

   // [RL5] reset held until the sequence reaches run
   // [RL12] debug logic reset only by supply sources
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sys_reset_o   <= 1'b1;
         dbg_reset_o   <= 1'b0;
         fuse_reload_o <= 1'b0;
         scan_run_o    <= 1'b0;
      end
      else
      begin
         sys_reset_o   <= state_next != RSTC_RUN;
         dbg_reset_o   <= (state_next != RSTC_RUN) &&
                          (seen_next[`RSTC_F_POR] | seen_next[`RSTC_F_BOD]);
         fuse_reload_o <= state_next == RSTC_LOAD;
         scan_run_o    <= state_next == RSTC_SCAN;
      end
   end

   // [RL2] fuse copies refreshed at the end of every reload
   // [RL7] unused brown-out detection forced to the lowest trigger
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_en_reg  <= 1'b0;
         bod_level_o <= `RSTC_BOD_LVL_MIN;
      end
      else if ((state_reg == RSTC_LOAD) && tmr_done && !any_req)
      begin
         pin_en_reg  <= f_pin_s;
         bod_level_o <= f_bod_s ? f_lvl_s : `RSTC_BOD_LVL_MIN;
      end
   end

   // [RL16] key opens a window of four instructions
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         unlock_reg <= `RSTC_UNLOCK_RST;
      end
      else if (unlock_key_i)
      begin
         unlock_reg <= `RSTC_UNLOCK_INSNS;
      end
      else if (sw_accept)
      begin
         unlock_reg <= `RSTC_UNLOCK_RST;
      end
      else if (insn_done_i && (unlock_reg != 3'h0))
      begin
         unlock_reg <= unlock_reg - 3'h1;
      end
   end

   assign unlocked  = unlock_reg != 3'h0;
   // writes act on the edge where the master sees ack
   assign wr_fire   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   // [RL17] writes outside the window change nothing
   assign sw_accept = wr_fire & unlocked & reg_hit(wb_adr_i, `RSTC_IDX_SOFTWARE_RESET_REQUEST);

   // [RL10] accepted trigger requests reset until the sequence takes it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sw_req_reg <= 1'b0;
      end
      else if (sw_accept && wb_dat_i[`RSTC_SOFT_RESET_TRIGGER_BIT])
      begin
         sw_req_reg <= 1'b1;
      end
      else if (state_reg == RSTC_HOLD)
      begin
         sw_req_reg <= 1'b0;
      end
   end

   // [RL18] write one clears, a commit in the same cycle wins
   // [RL19] power-on leaves only its own flag
   always_comb
   begin
      flags_next = flags_reg;
      if (wr_fire && reg_hit(wb_adr_i, `RSTC_IDX_FLAGS))
      begin
         flags_next = flags_reg & ~wb_dat_i[5:0];
      end
      if (commit && seen_reg[`RSTC_F_POR])
      begin
         flags_next = `RSTC_FLAGS_POR;
      end
      else if (commit)
      begin
         flags_next = flags_next | seen_reg;
      end
   end

   // [RL3] cause kept for software
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flags_reg <= `RSTC_FLAGS_RST;
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end

   // [RL4] flag layout, upper bits zero
   // [RL20] soft trigger and unmapped words read zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
             reg_hit(wb_adr_i, `RSTC_IDX_FLAGS))
         begin
            wb_dat_o <= {26'h0000000, flags_reg};
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_hold_to_load;
      state_reg == RSTC_HOLD ##1 state_reg == RSTC_LOAD;
   endsequence

   sequence s_boot_from_por;
      (commit && seen_reg[`RSTC_F_POR]) ##1 state_reg == RSTC_RUN;
   endsequence

   a_pin_holds_reset: assert property ( // [RL8]
      (pin_en_reg && !pin_n_s) |=> sys_reset_o [*2])
      else $error("pin low did not hold reset");

   a_por_only_flag: assert property ( // [RL19]
      s_boot_from_por |-> flags_reg == `RSTC_FLAGS_POR)
      else $error("power-on boot left other flags");

   a_soft_reset_trigger_reads_zero: assert property ( // [RL20]
      (wb_ack_o && !wb_we_i && $past(reg_hit(wb_adr_i, `RSTC_IDX_SOFTWARE_RESET_REQUEST)))
      |-> wb_dat_o == 32'h0000_0000)
      else $error("soft trigger read not zero");

   a_locked_ignored: assert property ( // [RL17]
      (wr_fire && !unlocked && !sw_req_reg) |=> !sw_req_reg)
      else $error("locked write started reset");

   a_soft_reset_fast: assert property ( // [RL10]
      (sw_accept && wb_dat_i[`RSTC_SOFT_RESET_TRIGGER_BIT]) |-> ##[1:A_SW_MAX] sys_reset_o)
      else $error("soft reset not started");

   a_dbg_supply_only: assert property ( // [RL12]
      $rose(dbg_reset_o) |-> $past(seen_next[`RSTC_F_POR] |
                                   seen_next[`RSTC_F_BOD]))
      else $error("debug reset without supply source");

   a_release_quiet: assert property ( // [RL21]
      $fell(sys_reset_o) |-> $past(!any_req) && $past(tmr_done))
      else $error("reset released early");

   a_fuse_reload: assert property ( // [RL2]
      s_hold_to_load |-> fuse_reload_o)
      else $error("fuse reload missing");

   // a supply drop in the same cycle legally adds the debug reset
   a_watchdog_reset: assert property ( // [RL9]
      (wdt_s && state_reg == RSTC_RUN) |=>
         sys_reset_o && (dbg_reset_o == $past(por_s | bod_s)))
      else $error("watchdog reset wrong");

endmodule

// ---- hw/rstc_sync2.sv ----
/*
 two flip-flop level synchroniser, parameterised width.
 assumes inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/1ns
module rstc_sync2
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // levels
   input  wire logic [WIDTH-1:0] async_i,
   input  wire logic [WIDTH-1:0] rst_val_i,
   output      logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;

   // first stage feeds the second stage only
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         // idle levels, so no false request right after reset
         meta_reg <= rst_val_i;
         sync_o   <= rst_val_i;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end

endmodule

// ---- hw/rstc_timer.sv ----
/*
 down counter for the initialisation phases; start reloads it.
 assumes start_i is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ns
module rstc_timer
#(
   parameter int TW = 20
)
(
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // control
   input  wire logic          start_i,
   input  wire logic [TW-1:0] load_i,
   output      logic          done_o
);

   logic [TW-1:0] cnt_reg;
   logic          run_reg;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done_o  <= 1'b0;
      end
      else if (start_i)
      begin
         cnt_reg <= load_i;
         run_reg <= 1'b1;
         done_o  <= 1'b0;
      end
      else if (run_reg)
      begin
         // done is a one-cycle pulse when the count runs out
         if (cnt_reg <= TW'(1))
         begin
            run_reg <= 1'b0;
            done_o  <= 1'b1;
         end
         cnt_reg <= cnt_reg - TW'(1);
      end
      else
      begin
         done_o <= 1'b0;
      end
   end

endmodule

// ---- inc/rstc_defines.svh ----
/*
 reset controller constants: register indices, flag positions, reset values.
 assumes inclusion by the bare name from the include path.
*/
`ifndef RSTC_DEFINES_SVH
`define RSTC_DEFINES_SVH

// register indices, byte address is four times the index
`define RSTC_IDX_FLAGS     6'h00
`define RSTC_IDX_SOFTWARE_RESET_REQUEST      6'h01

// reset_cause_flags bit positions
`define RSTC_F_POR         0
`define RSTC_F_BOD         1
`define RSTC_F_PIN         2
`define RSTC_F_WDT         3
`define RSTC_F_SOFT        4
`define RSTC_F_DBG         5
`define RSTC_FLAG_W        6

// software_reset_request field
`define RSTC_SOFT_RESET_TRIGGER_BIT      0

// reset values
`define RSTC_FLAGS_RST     6'h00
`define RSTC_FLAGS_POR     6'h01
`define RSTC_UNLOCK_RST    3'h0

// unlock window in cpu instructions
`define RSTC_UNLOCK_INSNS  3'h4

// brown-out trigger forced when detection is unused
`define RSTC_BOD_LVL_MIN   3'h0

`endif

// ---- inc/rstc_pkg.sv ----
/*
 reset controller types: sequencer state encoding.
 assumes nothing beyond a systemverilog compiler.
*/
package rstc_pkg;

   // gray codes along hold -> load -> start -> scan -> run
   typedef enum logic [2:0] {
      RSTC_HOLD  = 3'h0,
      RSTC_LOAD  = 3'h1,
      RSTC_START = 3'h3,
      RSTC_SCAN  = 3'h2,
      RSTC_RUN   = 3'h6
   } rstc_state_type;

endpackage

// ---- test/rstc_src_model.sv ----
/*
 far-side model: supply detectors, reset pin, watchdog and debugger.
 assumes the bench sets req_i just after a rising clock edge and holds
 each request for at least four clocks.
*/
`timescale 1ns/1ns
module rstc_src_model
(
   // request select: 0 por, 1 bod, 2 pin, 3 wdt, 4 debugger
   input  wire logic [4:0] req_i,
   // source levels
   output      logic       por_det_o,
   output      logic       bod_det_o,
   output      logic       reset_pin_n_o,
   output      logic       wdt_timeout_o,
   output      logic       dbg_reset_req_o
);
   assign por_det_o = req_i[0];
   assign bod_det_o = req_i[1];
   assign reset_pin_n_o = ~req_i[2];
   // time-out level, held by the bench past the synchroniser
   assign wdt_timeout_o = req_i[3];
   assign dbg_reset_req_o = req_i[4];
endmodule

// ---- test/system_reset_controller_tb.sv ----
/*
 self-checking bench for the reset controller: wishbone register tasks,
 one shared task for the source resets, one each for pin-off and soft reset, verdict at the end.
 assumes rstc_ctrl with short start-up and scan counts.
*/
`timescale 1ns/1ns
module system_reset_controller_tb;
   localparam int LOAD = 8;
   localparam int STEP = 4;
   localparam int SCAN = 8;
   localparam int STARTUP_DELAY_SELECT  = 2;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic        unlock_key_i = 1'b0;
   logic        insn_done_i = 1'b0;
   logic        fuse_pin_en = 1'b0;
   logic        fuse_bod_en = 1'b0;
   logic        fuse_scan = 1'b0;
   logic [4:0]  src_req = 5'h01;
   logic [31:0] wb_dat_o;
   logic [2:0]  bod_level_o;
   logic        wb_ack_o, sys_reset_o, dbg_reset_o, fuse_reload_o;
   logic        scan_run_o, por_det, bod_det, pin_n, wdt_to, dbg_req;
   logic        dbg_seen, reload_seen, scan_seen;
   int          fail_count = 0;
   int          num_checks = 0;
   int          cyc_count = 0;

   rstc_ctrl #(.TW(20), .LOAD_CYCLES(LOAD), .SUT_STEP_CYCLES(STEP),
      .SCAN_CYCLES(SCAN)) dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .por_det_i(por_det), .bod_det_i(bod_det),
      .reset_pin_n_i(pin_n), .wdt_timeout_i(wdt_to),
      .dbg_reset_req_i(dbg_req), .fuse_pin_reset_en_i(fuse_pin_en),
      .fuse_bod_en_i(fuse_bod_en), .fuse_bod_level_i(3'h5),
      .fuse_startup_sel_i(3'h2), .fuse_boot_scan_i(fuse_scan),
      .unlock_key_i(unlock_key_i), .insn_done_i(insn_done_i),
      .sys_reset_o(sys_reset_o), .dbg_reset_o(dbg_reset_o),
      .fuse_reload_o(fuse_reload_o), .scan_run_o(scan_run_o),
      .bod_level_o(bod_level_o)
   );

   rstc_src_model src
   (
      .req_i(src_req), .por_det_o(por_det), .bod_det_o(bod_det),
      .reset_pin_n_o(pin_n), .wdt_timeout_o(wdt_to),
      .dbg_reset_req_o(dbg_req)
   );

   always #25 clk_i = ~clk_i;

   // sampled mid-cycle so the flags never race the design's edge
   always @(negedge clk_i)
   begin
      if (dbg_reset_o === 1'b1) dbg_seen = 1'b1;
      if (fuse_reload_o === 1'b1) reload_seen = 1'b1;
      if (scan_run_o === 1'b1) scan_seen = 1'b1;
   end

   always @(posedge clk_i)
   begin
      cyc_count = cyc_count + 1;
      if (cyc_count == 4000)
      begin
         fail_count = fail_count + 1;
         print_verdict();
      end
   end

   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp)
         begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
         end
      end
   endtask

   // entered just after a rising edge; waits for ack, no fixed latency
   task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                output logic [31:0] q);
      int n;
      begin
         n = 0;
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= we;
         wb_adr_i <= adr;
         wb_dat_i <= d;
         wb_sel_i <= 4'h1;
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1 && n < 20)
         begin
            @(posedge clk_i);
            n = n + 1;
         end
         check(32'(wb_ack_o), 32'h1);
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   task rd_check(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] q;
      begin
         wb_xfer(1'b0, adr, 32'h0, q);
         check(q, exp);
      end
   endtask

   task clear_seen;
      begin
         dbg_seen = 1'b0;
         reload_seen = 1'b0;
         scan_seen = 1'b0;
      end
   endtask

   // waits out initialisation, then judges its length, side outputs, flags
   task settle(input logic [7:0] flags, input logic sup, input logic scan);
      int n;
      int thr;
      logic [31:0] q;
      begin
         n = 0;
         thr = LOAD + (sup ? STARTUP_DELAY_SELECT * STEP : 0) + (scan ? SCAN : 0);
         while (sys_reset_o !== 1'b0 && n < 300)
         begin
            @(posedge clk_i);
            n = n + 1;
         end
         check(32'(n + 2 >= thr && n < thr + 8), 32'h1);
         check(32'(dbg_seen), 32'(sup));
         check(32'(reload_seen), 32'h1);
         check(32'(scan_seen), 32'(scan));
         rd_check(8'h00, {24'h0, flags});
         wb_xfer(1'b1, 8'h00, 32'h3f, q);
         rd_check(8'h00, 32'h0);
      end
   endtask

   task fire(input logic [4:0] srcs, input int hold, input logic [7:0] flags,
             input logic sup, input logic scan);
      int n;
      begin
         n = 0;
         clear_seen();
         src_req <= srcs;
         @(posedge clk_i);
         while (sys_reset_o !== 1'b1 && n < 6)
         begin
            @(posedge clk_i);
            n = n + 1;
         end
         check(32'(sys_reset_o), 32'h1);
         repeat (hold) @(posedge clk_i);
         check(32'(sys_reset_o), 32'h1);
         src_req <= 5'h00;
         settle(flags, sup, scan);
      end
   endtask

   // pin fuse still off: a low pin must not reset
   task pin_off;
      begin
         src_req <= 5'h04;
         repeat (10) @(posedge clk_i);
         check(32'(sys_reset_o), 32'h0);
         src_req <= 5'h00;
         repeat (4) @(posedge clk_i);
      end
   endtask

   task soft_try(input logic key, input int insns, input logic exp);
      logic [31:0] q;
      begin
         clear_seen();
         unlock_key_i <= key;
         @(posedge clk_i);
         unlock_key_i <= 1'b0;
         repeat (insns)
         begin
            insn_done_i <= 1'b1;
            @(posedge clk_i);
         end
         insn_done_i <= 1'b0;
         wb_xfer(1'b1, 8'h04, 32'h1, q);
         @(posedge clk_i);
         check(32'(sys_reset_o), 32'(exp));
      end
   endtask

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      fire(5'h01, 4, 8'h01, 1'b1, 1'b0);
      check(32'(bod_level_o), 32'h0);
      pin_off();
      fuse_pin_en <= 1'b1;
      fuse_scan <= 1'b1;
      fire(5'h08, 6, 8'h08, 1'b0, 1'b1);
      fuse_scan <= 1'b0;
      fire(5'h04, 30, 8'h04, 1'b0, 1'b0);
      fire(5'h18, 6, 8'h28, 1'b0, 1'b0);
      fuse_bod_en <= 1'b1;
      fire(5'h02, 6, 8'h02, 1'b1, 1'b0);
      check(32'(bod_level_o), 32'h5);
      soft_try(1'b0, 0, 1'b0);
      soft_try(1'b1, 4, 1'b0);
      rd_check(8'h04, 32'h0);
      soft_try(1'b1, 3, 1'b1);
      settle(8'h10, 1'b0, 1'b0);
      fire(5'h09, 6, 8'h01, 1'b1, 1'b0);
      rd_check(8'h08, 32'h0);
      print_verdict();
   end
endmodule
